/* File: design/uart_pkg.sv */
/*
 * shared constants and carriers of the uart data buffer and baud generator.
 * assumes an 8-bit special-function register bus with 8-bit addresses.
 */
package uart_pkg;

    // ------------------------------------------------------------------
    // register addresses and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_DATA_BUF   = 8'h99;
    localparam logic [7:0] ADDR_BAUD_CTRL  = 8'hab;
    localparam logic [7:0] ADDR_RELOAD_LO  = 8'hac;
    localparam logic [7:0] ADDR_RELOAD_HI  = 8'had;
    localparam int         CTRL_EN_BIT     = 6;
    localparam int         CTRL_PS_LSB     = 0;
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [1:0] RESET_PS        = 2'h0;

    // ------------------------------------------------------------------
    // prescaler terminal counts (divide minus one) and framing counts
    // ------------------------------------------------------------------
    localparam logic [5:0]  PS_LAST_DIV12  = 6'h0b;
    localparam logic [5:0]  PS_LAST_DIV4   = 6'h03;
    localparam logic [5:0]  PS_LAST_DIV48  = 6'h2f;
    localparam logic [5:0]  PS_LAST_DIV1   = 6'h00;
    localparam logic [15:0] CNT_MAX        = 16'hffff;
    localparam logic [3:0]  TICK_LAST      = 4'hf;   // 16 generator ticks per bit
    localparam logic [3:0]  TICK_HALF      = 4'h7;
    localparam logic [2:0]  BIT_LAST       = 3'h7;
    localparam int          FIFO_DEPTH     = 8;
    localparam int          FIFO_WIDTH     = 8;

    // ------------------------------------------------------------------
    // carriers and states
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_t;

    typedef struct packed {
        logic       enable;
        logic [1:0] prescale;
        logic [7:0] reload_high;
        logic [7:0] reload_low;
    } baud_cfg_t;

    typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_PUSH} rx_state_t;

endpackage

/* File: design/byte_fifo.sv */
/*
 * small synchronous fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             push, pop;

    // honest flags: full and empty follow the occupancy count
    assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // pointer and count update
    always_comb begin
        wp_nxt  = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
        rp_nxt  = pop  ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage needs no reset; only written words are ever read
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    AST_FIFO_NO_OVER: assert property (@(posedge core_clk) disable iff (rst)
        (cnt_r == (AW+1)'(DEPTH)) |-> !in_ready)
        else $error("fifo accepts while full");
endmodule
`default_nettype wire

/* File: design/baud_gen.sv */
/*
 * baud generator: prescaler plus 16-bit reload counter, one tick per rollover.
 * assumes configuration comes from registers on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module baud_gen
    import uart_pkg::*;
(
    // clock and reset
    input  wire logic      core_clk,
    input  wire logic      rst,
    // configuration
    input  wire baud_cfg_t cfg,
    // timing tick
    output logic           baud_tick
);
    logic [5:0]  ps_r, ps_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic        tick_r, tick_nxt;
    logic        ps_tick;

    // terminal prescaler count for each select code
    function automatic logic [5:0] ps_last(input logic [1:0] sel);
        case (sel)
            2'b00:   ps_last = PS_LAST_DIV12;
            2'b01:   ps_last = PS_LAST_DIV4;
            2'b10:   ps_last = PS_LAST_DIV48;
            default: ps_last = PS_LAST_DIV1;
        endcase
    endfunction

    assign ps_tick   = cfg.enable & (ps_r >= ps_last(cfg.prescale));
    assign baud_tick = tick_r;

    // prescaler and reload counter; disabled means frozen count
    always_comb begin
        ps_nxt   = ps_r;
        cnt_nxt  = cnt_r;
        tick_nxt = 1'b0;
        if (!cfg.enable) begin
            ps_nxt = '0;
        end else if (ps_tick) begin
            ps_nxt = '0;
            if (cnt_r == CNT_MAX) begin
                cnt_nxt  = {cfg.reload_high, cfg.reload_low};
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end else begin
            ps_nxt = ps_r + 6'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ps_r   <= '0;
            cnt_r  <= '0;
            tick_r <= 1'b0;
        end else begin
            ps_r   <= ps_nxt;
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    AST_RELOAD: assert property (@(posedge core_clk) disable iff (rst)
        (ps_tick && cnt_r == CNT_MAX) |=> (cnt_r[15:8] == $past(cfg.reload_high)) && tick_r)
        else $error("high byte not reloaded on rollover");
    AST_RELOAD_LO: assert property (@(posedge core_clk) disable iff (rst)
        (ps_tick && cnt_r == CNT_MAX) |=> (cnt_r[7:0] == $past(cfg.reload_low)))
        else $error("low byte not reloaded on rollover");
    AST_STOPPED: assert property (@(posedge core_clk) disable iff (rst)
        !cfg.enable |=> $stable(cnt_r) && !tick_r)
        else $error("generator moves while disabled");
    AST_DIV12: assert property (@(posedge core_clk) disable iff (rst)
        (ps_tick && cfg.prescale == 2'b00 && cfg.enable) ##1 (cfg.prescale == 2'b00
        && cfg.enable)[*8] |-> !ps_tick)
        else $error("divide by 12 ticks early");
    AST_DIV1: assert property (@(posedge core_clk) disable iff (rst)
        (cfg.enable && cfg.prescale == 2'b11)[*2] |-> ps_tick)
        else $error("divide by 1 does not tick every cycle");
endmodule
`default_nettype wire

/* File: design/uart_core.sv */
/*
 * uart data buffer and baud generator: sfr registers, 8n1 transmitter,
 * receiver with an 8-byte queue in front of the receive latch.
 * assumes the cpu sfr bus on core_clk and an asynchronous receive pin.
 */
// Function
// - data buffer write loads shifter, starts sending
// - data buffer read returns receive latch
// - enable bit 6 zero stops generator, uart
// - prescale select divides by 12,4,48,1
// - reserved control bits read zero, write zero
// - rollover reloads counter high byte
// - rollover reloads counter low byte
// - transmit done set at stop bit start
// - receive done set, held while queue holds data
`timescale 1ns/100ps
`default_nettype none
module uart_core
    import uart_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // sfr bus
    input  wire sfr_req_t   sfr_req,
    output logic [7:0]      sfr_rdata,
    // done flags
    output logic            transmit_done_flag,
    input  wire logic       tx_flag_clr,
    output logic            receive_done_flag,
    input  wire logic       rx_flag_clr,
    // serial line
    output logic            txd_out,
    input  wire logic       rxd_in
);
    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic       en_r, en_nxt;
    logic [1:0] ps_r, ps_nxt;
    logic [7:0] rl_lo_r, rl_lo_nxt, rl_hi_r, rl_hi_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [7:0] rx_latch_r, rx_latch_nxt;
    logic       txf_r, txf_nxt, rxf_r, rxf_nxt;
    logic       buf_wr, buf_rd;
    logic       baud_tick;
    baud_cfg_t  cfg;

    assign buf_wr = sfr_req.wr & (sfr_req.addr == ADDR_DATA_BUF);
    assign buf_rd = sfr_req.rd & (sfr_req.addr == ADDR_DATA_BUF);
    assign cfg    = '{enable: en_r, prescale: ps_r, reload_high: rl_hi_r,
                      reload_low: rl_lo_r};

    // reads return a registered byte one cycle later; unmapped reads give zero
    always_comb begin
        en_nxt    = en_r;
        ps_nxt    = ps_r;
        rl_lo_nxt = rl_lo_r;
        rl_hi_nxt = rl_hi_r;
        rdata_nxt = rdata_r;
        if (sfr_req.wr) begin
            case (sfr_req.addr)
                ADDR_BAUD_CTRL: begin
                    // reserved bits are not stored, so they cannot read back
                    en_nxt = sfr_req.wdata[CTRL_EN_BIT];
                    ps_nxt = sfr_req.wdata[CTRL_PS_LSB +: 2];
                end
                ADDR_RELOAD_LO: rl_lo_nxt = sfr_req.wdata;
                ADDR_RELOAD_HI: rl_hi_nxt = sfr_req.wdata;
                default: ;
            endcase
        end
        if (sfr_req.rd) begin
            case (sfr_req.addr)
                ADDR_DATA_BUF:  rdata_nxt = rx_latch_r;
                ADDR_BAUD_CTRL: rdata_nxt = {1'b0, en_r, 4'h0, ps_r};
                ADDR_RELOAD_LO: rdata_nxt = rl_lo_r;
                ADDR_RELOAD_HI: rdata_nxt = rl_hi_r;
                default:        rdata_nxt = RESET_BYTE;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            en_r    <= 1'b0;
            ps_r    <= RESET_PS;
            rl_lo_r <= RESET_BYTE;
            rl_hi_r <= RESET_BYTE;
            rdata_r <= RESET_BYTE;
        end else begin
            en_r    <= en_nxt;
            ps_r    <= ps_nxt;
            rl_lo_r <= rl_lo_nxt;
            rl_hi_r <= rl_hi_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign sfr_rdata = rdata_r;

    baud_gen u_baud (
        .core_clk  (core_clk),
        .rst       (rst),
        .cfg       (cfg),
        .baud_tick (baud_tick)
    );

    // ------------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------------
    tx_state_t  tx_st_r, tx_st_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic [3:0] tx_tk_r, tx_tk_nxt;
    logic [2:0] tx_bit_r, tx_bit_nxt;
    logic       txd_r, txd_nxt;
    logic       tx_bit_end, tx_stop_enter;

    assign tx_bit_end = baud_tick & (tx_tk_r == TICK_LAST);

    // writes while a frame is in flight are ignored; start bit drives at once
    always_comb begin
        tx_st_nxt     = tx_st_r;
        tx_sh_nxt     = tx_sh_r;
        tx_tk_nxt     = baud_tick ? tx_tk_r + 4'h1 : tx_tk_r;
        tx_bit_nxt    = tx_bit_r;
        txd_nxt       = txd_r;
        tx_stop_enter = 1'b0;
        case (tx_st_r)
            TX_IDLE: begin
                txd_nxt   = 1'b1;
                tx_tk_nxt = '0;
                if (buf_wr && en_r) begin
                    tx_sh_nxt = sfr_req.wdata;
                    tx_st_nxt = TX_START;
                    txd_nxt   = 1'b0;
                end
            end
            TX_START: begin
                if (tx_bit_end) begin
                    tx_st_nxt  = TX_DATA;
                    tx_bit_nxt = '0;
                    txd_nxt    = tx_sh_r[0];
                end
            end
            TX_DATA: begin
                if (tx_bit_end) begin
                    tx_sh_nxt  = {1'b0, tx_sh_r[7:1]};
                    tx_bit_nxt = tx_bit_r + 3'h1;
                    txd_nxt    = tx_sh_r[1];
                    if (tx_bit_r == BIT_LAST) begin
                        tx_st_nxt     = TX_STOP;
                        txd_nxt       = 1'b1;
                        tx_stop_enter = en_r;
                    end
                end
            end
            TX_STOP: begin
                if (tx_bit_end) begin
                    tx_st_nxt = TX_IDLE;
                end
            end
            default: tx_st_nxt = TX_IDLE;
        endcase
        if (!en_r) begin
            tx_st_nxt = TX_IDLE;
            txd_nxt   = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_st_r  <= TX_IDLE;
            tx_sh_r  <= RESET_BYTE;
            tx_tk_r  <= '0;
            tx_bit_r <= '0;
            txd_r    <= 1'b1;
        end else begin
            tx_st_r  <= tx_st_nxt;
            tx_sh_r  <= tx_sh_nxt;
            tx_tk_r  <= tx_tk_nxt;
            tx_bit_r <= tx_bit_nxt;
            txd_r    <= txd_nxt;
        end
    end

    assign txd_out = txd_r;

    // ------------------------------------------------------------------
    // receiver: pin passes two flops before anything looks at it
    // ------------------------------------------------------------------
    rx_state_t  rx_st_r, rx_st_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic [3:0] rx_tk_r, rx_tk_nxt;
    logic [2:0] rx_bit_r, rx_bit_nxt;
    logic       rx_meta_r, rx_sync_r;
    logic       q_in_valid, q_in_ready, q_out_valid, q_pop;
    logic [7:0] q_out_data;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= rxd_in;
            rx_sync_r <= rx_meta_r;
        end
    end

    // sixteen ticks per bit; start is confirmed at mid-bit to reject glitches
    always_comb begin
        rx_st_nxt  = rx_st_r;
        rx_sh_nxt  = rx_sh_r;
        rx_tk_nxt  = baud_tick ? rx_tk_r + 4'h1 : rx_tk_r;
        rx_bit_nxt = rx_bit_r;
        q_in_valid = 1'b0;
        case (rx_st_r)
            RX_IDLE: begin
                rx_tk_nxt = '0;
                if (baud_tick && !rx_sync_r) begin
                    rx_st_nxt = RX_START;
                end
            end
            RX_START: begin
                if (baud_tick && rx_tk_r == TICK_HALF) begin
                    rx_tk_nxt  = '0;
                    rx_bit_nxt = '0;
                    rx_st_nxt  = rx_sync_r ? RX_IDLE : RX_DATA;
                end
            end
            RX_DATA: begin
                if (baud_tick && rx_tk_r == TICK_LAST) begin
                    rx_sh_nxt  = {rx_sync_r, rx_sh_r[7:1]};
                    rx_bit_nxt = rx_bit_r + 3'h1;
                    if (rx_bit_r == BIT_LAST) begin
                        rx_st_nxt = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                // a low stop bit is a framing error and the byte is dropped
                if (baud_tick && rx_tk_r == TICK_LAST) begin
                    rx_st_nxt = rx_sync_r ? RX_PUSH : RX_IDLE;
                end
            end
            RX_PUSH: begin
                // a full queue stalls here; later frames are missed meanwhile
                q_in_valid = 1'b1;
                if (q_in_ready) begin
                    rx_st_nxt = RX_IDLE;
                end
            end
            default: rx_st_nxt = RX_IDLE;
        endcase
        if (!en_r) begin
            rx_st_nxt = RX_IDLE;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_st_r  <= RX_IDLE;
            rx_sh_r  <= RESET_BYTE;
            rx_tk_r  <= '0;
            rx_bit_r <= '0;
        end else begin
            rx_st_r  <= rx_st_nxt;
            rx_sh_r  <= rx_sh_nxt;
            rx_tk_r  <= rx_tk_nxt;
            rx_bit_r <= rx_bit_nxt;
        end
    end

    byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_rxq (
        .core_clk  (core_clk),
        .rst       (rst),
        .in_valid  (q_in_valid),
        .in_ready  (q_in_ready),
        .in_data   (rx_sh_r),
        .out_valid (q_out_valid),
        .out_ready (q_pop),
        .out_data  (q_out_data)
    );

    // ------------------------------------------------------------------
    // done flags and receive latch; a set always beats a clear
    // ------------------------------------------------------------------
    assign q_pop = q_out_valid & (!rxf_r | rx_flag_clr);

    always_comb begin
        rx_latch_nxt = q_pop ? q_out_data : rx_latch_r;
        rxf_nxt      = q_pop ? 1'b1 : (rx_flag_clr ? 1'b0 : rxf_r);
        txf_nxt      = tx_stop_enter ? 1'b1 : (tx_flag_clr ? 1'b0 : txf_r);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rx_latch_r <= RESET_BYTE;
            rxf_r      <= 1'b0;
            txf_r      <= 1'b0;
        end else begin
            rx_latch_r <= rx_latch_nxt;
            rxf_r      <= rxf_nxt;
            txf_r      <= txf_nxt;
        end
    end

    assign transmit_done_flag = txf_r;
    assign receive_done_flag  = rxf_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_tx_load;
        buf_wr && en_r && tx_st_r == TX_IDLE;
    endsequence

    AST_TX_START: assert property (@(posedge core_clk) disable iff (rst)
        s_tx_load |=> !txd_out && tx_sh_r == $past(sfr_req.wdata))
        else $error("write did not start transmission");
    AST_RD_LATCH: assert property (@(posedge core_clk) disable iff (rst)
        buf_rd |=> sfr_rdata == $past(rx_latch_r))
        else $error("data buffer read not from receive latch");
    AST_CTRL_RSV: assert property (@(posedge core_clk) disable iff (rst)
        (sfr_req.rd && sfr_req.addr == ADDR_BAUD_CTRL) |=> sfr_rdata[7] == 1'b0
        && sfr_rdata[5:2] == 4'h0 && sfr_rdata[6] == $past(en_r))
        else $error("control readback wrong");
    AST_DISABLED: assert property (@(posedge core_clk) disable iff (rst)
        !en_r |=> tx_st_r == TX_IDLE && rx_st_r == RX_IDLE && txd_out)
        else $error("uart active while generator disabled");
    AST_TXF_SET: assert property (@(posedge core_clk) disable iff (rst)
        tx_stop_enter |=> transmit_done_flag && txd_out && tx_st_r == TX_STOP)
        else $error("transmit done not set at stop bit");
    AST_RXF_SET: assert property (@(posedge core_clk) disable iff (rst)
        q_pop |=> receive_done_flag && rx_latch_r == $past(q_out_data))
        else $error("receive done not set on latch load");
    AST_RXF_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        (receive_done_flag && q_out_valid) |=> receive_done_flag)
        else $error("receive done cleared while queue holds data");
endmodule
`default_nettype wire

/* File: sim/line_peer.sv */
/*
 * serial line peer: decodes the block's transmit line, sends 8n1 frames on its receive line.
 * assumes a fixed bit length in core clock cycles and an idle-high line.
 */
`timescale 1ns/100ps
`default_nettype none
module line_peer #(
    parameter int BIT_CYC = 256
) (
    // clock
    input  wire logic  core_clk,
    // serial line
    input  wire logic  line_in,
    output logic       line_out,
    // last decoded byte
    output logic [7:0] got_byte
);
    // ------------------------------------------------------------------
    // receive: sample mid-bit, lsb first; no resync, so leave the line idle
    // ------------------------------------------------------------------
    initial begin
        got_byte = 8'h00;
        line_out = 1'b1;
        forever begin
            @(negedge line_in);
            repeat (BIT_CYC / 2) @(posedge core_clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYC) @(posedge core_clk);
                got_byte[i] = line_in;
            end
        end
    end

    // one frame out, returns at the end of the stop bit
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            line_out <= f[i];
            repeat (BIT_CYC) @(negedge core_clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: sim/uart_core_bench.sv */
/*
 * bench for uart_core: registers, bit timing per setting, receive queue, one frame out.
 * assumes line_peer on the serial pins at 256 cycles per bit.
 */
`timescale 1ns/100ps
`default_nettype none
module uart_core_bench
    import uart_pkg::*;
;
    // ------------------------------------------------------------------
    // pins and counters
    // ------------------------------------------------------------------
    logic       core_clk = 1'b0;
    logic       rst;
    sfr_req_t   sfr_req;
    logic [7:0] sfr_rdata;
    logic       tx_done;
    logic       tx_flag_clr;
    logic       rx_done;
    logic       rx_flag_clr;
    logic       txd;
    logic       rxd;
    logic [7:0] got_byte;
    int         num_errors = 0;
    int         tests_run = 0;

    // 20 MHz core clock
    always #25 core_clk = ~core_clk;

    uart_core uut (.core_clk(core_clk), .rst(rst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
        .transmit_done_flag(tx_done), .tx_flag_clr(tx_flag_clr),
        .receive_done_flag(rx_done), .rx_flag_clr(rx_flag_clr), .txd_out(txd), .rxd_in(rxd));
    line_peer peer (.core_clk(core_clk), .line_in(txd), .line_out(rxd), .got_byte(got_byte));

    // ------------------------------------------------------------------
    // shared tasks; all enter and leave at a falling edge
    // ------------------------------------------------------------------
    task automatic close_out();
        if (num_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge core_clk);
        sfr_req <= '0;
        @(negedge core_clk);
    endtask

    // data is taken one cycle late; it holds until the next read anyway
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge core_clk);
        sfr_req <= '0;
        @(negedge core_clk);
        d = sfr_rdata;
    endtask

    // bounded wait on the transmit line or the transmit flag; n counts cycles
    task automatic wait_for(input logic flag, input logic lvl, output int n);
        n = 0;
        while ((flag ? tx_done : txd) !== lvl) begin
            @(negedge core_clk);
            n++;
            if (n > 70000) begin
                num_errors++;
                close_out();
            end
        end
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic regs();
        logic [7:0] d;
        logic [7:0] adr [4] = '{ADDR_DATA_BUF, ADDR_BAUD_CTRL, ADDR_RELOAD_LO, ADDR_RELOAD_HI};
        foreach (adr[i]) begin
            rd(adr[i], d);
            check("reset value", 16'h0000, {8'h00, d});
        end
        wr(ADDR_BAUD_CTRL, 8'h43);
        wr(ADDR_RELOAD_HI, 8'ha5);
        wr(ADDR_RELOAD_LO, 8'h5a);
        rd(ADDR_BAUD_CTRL, d);
        check("control", 16'h0043, {8'h00, d});
        rd(ADDR_RELOAD_HI, d);
        check("reload high", 16'h00a5, {8'h00, d});
        rd(ADDR_RELOAD_LO, d);
        check("reload low", 16'h005a, {8'h00, d});
        rd(8'h9a, d);
        check("unmapped", 16'h0000, {8'h00, d});
        wr(ADDR_BAUD_CTRL, 8'h00);
        wr(ADDR_DATA_BUF, 8'h55);
        repeat (20) @(negedge core_clk);
        check("txd while stopped", 16'h0001, {15'h0000, txd});
    endtask

    // 0x55 gives a high bit 0 whose length is exactly 16 generator ticks
    task automatic measure(input logic [1:0] ps, input logic [15:0] rl, input logic [15:0] exp);
        int n;
        wr(ADDR_RELOAD_HI, rl[15:8]);
        wr(ADDR_RELOAD_LO, rl[7:0]);
        wr(ADDR_BAUD_CTRL, {2'b01, 4'h0, ps});
        wr(ADDR_DATA_BUF, 8'h55);
        check("start bit", 16'h0000, {15'h0000, txd});
        wait_for(1'b0, 1'b1, n);
        wait_for(1'b0, 1'b0, n);
        check("bit cycles", exp, n[15:0]);
        wr(ADDR_BAUD_CTRL, 8'h00);
        repeat (2) @(negedge core_clk);
        check("txd after abort", 16'h0001, {15'h0000, txd});
    endtask

    // latch plus eight queue words plus the stalled receiver hold ten bytes
    task automatic rx_fill();
        logic [7:0] d;
        wr(ADDR_RELOAD_HI, 8'hff);
        wr(ADDR_RELOAD_LO, 8'hf0);
        wr(ADDR_BAUD_CTRL, 8'h43);
        repeat (300) @(negedge core_clk);
        for (int i = 0; i < 10; i++) begin
            peer.send(8'h30 + 8'(i));
        end
        for (int i = 0; i < 10; i++) begin
            repeat (4) @(negedge core_clk);
            check("rx flag", 16'h0001, {15'h0000, rx_done});
            rd(ADDR_DATA_BUF, d);
            check("rx byte", 16'h0030 + 16'(i), {8'h00, d});
            rx_flag_clr <= 1'b1;
            @(negedge core_clk);
            rx_flag_clr <= 1'b0;
        end
        repeat (4) @(negedge core_clk);
        check("rx flag empty", 16'h0000, {15'h0000, rx_done});
    endtask

    task automatic tx_frame();
        int n;
        logic [7:0] d;
        wr(ADDR_DATA_BUF, 8'h3c);
        wait_for(1'b1, 1'b1, n);
        check("done time", 16'h0001, {15'h0000, n > 2280 && n < 2330});
        check("stop level", 16'h0001, {15'h0000, txd});
        check("peer byte", 16'h003c, {8'h00, got_byte});
        rd(ADDR_DATA_BUF, d);
        check("latch kept", 16'h0039, {8'h00, d});
        repeat (300) @(negedge core_clk);
        check("done sticky", 16'h0001, {15'h0000, tx_done});
        tx_flag_clr <= 1'b1;
        @(negedge core_clk);
        tx_flag_clr <= 1'b0;
        @(negedge core_clk);
        check("done cleared", 16'h0000, {15'h0000, tx_done});
    endtask

    // ------------------------------------------------------------------
    // main sequence; first enable counts from zero, so it costs 65536 cycles
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        sfr_req = '0;
        tx_flag_clr = 1'b0;
        rx_flag_clr = 1'b0;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        regs();
        measure(2'h3, 16'hffff, 16'h0010);
        measure(2'h1, 16'hffff, 16'h0040);
        measure(2'h0, 16'hffff, 16'h00c0);
        measure(2'h2, 16'hffff, 16'h0300);
        measure(2'h3, 16'hfff0, 16'h0100);
        measure(2'h3, 16'hfeff, 16'h1010);
        rx_fill();
        tx_frame();
        close_out();
    end
endmodule
`default_nettype wire
